// file: verilog/cis_pkg.sv
// Purpose: constants for the cpu interrupt sequencer
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   vectors are 16-bit addresses of the high byte of each pair
package cis_pkg;
  // register map (byte addresses)
  localparam logic [7:0] CIS_MISC_OFS    = 8'h00;
  localparam logic [7:0] CIS_CCR_OFS     = 8'h04;
  localparam logic [7:0] CIS_CMD_OFS     = 8'h08;
  localparam logic [7:0] CIS_ALU_OFS     = 8'h0C;
  localparam logic [7:0] CIS_SRC_OFS     = 8'h10;
  localparam logic [7:0] CIS_STAT_OFS    = 8'h14;
  localparam logic [7:0] CIS_PULL_OFS    = 8'h18;
  // misc_control_status bit positions
  localparam int CIS_MISC_EN_BIT  = 7;
  localparam int CIS_MISC_SNS_BIT = 6;
  localparam int CIS_MISC_IND_BIT = 2;
  // condition code bit positions
  localparam int CIS_CC_H = 4;
  localparam int CIS_CC_I = 3;
  localparam int CIS_CC_N = 2;
  localparam int CIS_CC_Z = 1;
  localparam int CIS_CC_C = 0;
  localparam logic [7:0] CIS_CC_UPPER  = 8'hE0;
  localparam logic [7:0] CIS_CC_RESET  = 8'hE8;
  // command register bits
  localparam int CIS_CMD_DONE = 0;
  localparam int CIS_CMD_TRAP = 1;
  localparam int CIS_CMD_RTI  = 2;
  localparam int CIS_CMD_CLI  = 3;
  localparam int CIS_CMD_SEI  = 4;
  localparam int CIS_CMD_WAIT = 5;
  // alu result register fields
  localparam int CIS_ALU_CLS_LSB = 8;
  localparam int CIS_ALU_C_BIT   = 12;
  localparam int CIS_ALU_H_BIT   = 13;
  // alu operation classes
  localparam logic [3:0] CIS_OP_ARITH = 4'h1;
  localparam logic [3:0] CIS_OP_LOGIC = 4'h2;
  localparam logic [3:0] CIS_OP_LOAD  = 4'h3;
  localparam logic [3:0] CIS_OP_SHIFT = 4'h4;
  localparam logic [3:0] CIS_OP_INCDC = 4'h5;
  localparam logic [3:0] CIS_OP_ADD   = 4'h6;
  localparam logic [3:0] CIS_OP_BTST  = 4'h7;
  // vectors
  localparam logic [15:0] CIS_VEC_RESET = 16'h1FFE;
  localparam logic [15:0] CIS_VEC_TRAP  = 16'h1FFC;
  localparam logic [15:0] CIS_VEC_EXT   = 16'h1FFA;
  localparam logic [15:0] CIS_VEC_TMR16 = 16'h1FF8;
  localparam logic [15:0] CIS_VEC_TMR8  = 16'h1FF6;
  localparam logic [15:0] CIS_VEC_KEY   = 16'h1FF4;
  // stack frame
  localparam logic [2:0] CIS_FRAME_LEN = 3'h5;
  localparam logic [2:0] CIS_CALL_LEN  = 3'h2;
  localparam logic [5:0] CIS_SP_RESET  = 6'h3F;
  localparam logic [15:0] CIS_SP_BASE  = 16'h00C0;
  typedef enum logic [2:0] {
    CIS_SRC_NONE, CIS_SRC_EXT, CIS_SRC_TMR16, CIS_SRC_TMR8, CIS_SRC_KEY, CIS_SRC_TRAP
  } cis_src_t;
endpackage

// file: verilog/cis_sequencer.sv
// Purpose: interrupt masking, priority and entry/exit sequencing
// Assumes: core issues commands and stack data through wishbone registers
// Notes:   a stack write and a vector fetch each take one cycle here
`timescale 1ns/1ps
module cis_sequencer
  import cis_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // core register values to stack
  input  wire logic [15:0] pc_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  idx_i,
  // internal interrupt sources, levels
  input  wire logic        tmr16_req_i,
  input  wire logic        tmr8_req_i,
  input  wire logic        key_req_i,
  // shared request / indicator pin
  input  wire logic        req_pin_i,
  output logic             req_pin_o,
  output logic             req_pin_oe_n_o,
  // stack and vector bus
  output logic             stk_we_o,
  output logic             stk_re_o,
  output logic [15:0]      stk_adr_o,
  output logic [7:0]       stk_dat_o,
  output logic             vec_fetch_o,
  output logic [15:0]      vec_adr_o,
  output logic             busy_o,
  output logic [7:0]       ccr_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_MASK, ST_VEC, ST_PULL} cis_state_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
    logic [7:0]  condition_code_reg;
    logic        en;
    logic        sns;
    logic        ind;
    logic        pin_d;
    logic        latch;
    cis_state_t  st;
    logic [2:0]  cnt;
    logic [5:0]  sp;
    cis_src_t    src;
    logic [39:0] frame;
    logic [39:0] pulled;
    logic        stk_we;
    logic        stk_re;
    logic [15:0] stk_adr;
    logic [7:0]  stk_dat;
    logic        vf;
    logic [15:0] va;
    logic        trap_pend;
    logic        rti_pend;
    logic        boot;
    // registered copies of derived outputs and the return hand-off
    logic        busy;
    logic        oe_n;
    logic        ccr_wait;
  } cis_s_t;

  cis_s_t s_reg, s_next;

  // bus decode for the access seen at this edge
  logic        wr;
  logic        rd;
  logic        done_wr;
  logic        pull_wr;
  // pin event decode
  logic        fall;
  logic        trig;
  // request selection
  logic        mask_now;
  logic        pend_ext;
  cis_src_t    win;
  logic [15:0] win_vec;
  // alu result fields
  logic [7:0]  res;
  logic [3:0]  cls;

  always_comb begin
    s_next = s_reg;

    // a write lands on the edge that sees ack high, the only edge
    // at which the master knows it was taken; a read is answered
    // from the edge before so that its data stands with ack
    wr      = cyc_i && stb_i && we_i && s_reg.ack && sel_i[0];
    rd      = cyc_i && stb_i && !we_i && !s_reg.ack;
    done_wr = wr && (adr_i == CIS_CMD_OFS) && dat_i[CIS_CMD_DONE];
    pull_wr = wr && (adr_i == CIS_PULL_OFS);
    res     = dat_i[7:0];
    cls     = dat_i[CIS_ALU_CLS_LSB +: 4];

    mask_now = s_reg.condition_code_reg[CIS_CC_I];
    pend_ext = 1'b0;
    win      = CIS_SRC_NONE;

    // single-cycle strobes fall back unless a state raises them
    s_next.ack    = cyc_i && stb_i && !s_reg.ack;
    s_next.stk_we = 1'b0;
    s_next.stk_re = 1'b0;
    s_next.vf     = 1'b0;
    s_next.pin_d  = req_pin_i;
    s_next.boot   = 1'b0;

    fall = s_reg.pin_d && !req_pin_i;
    // low level also requests when not edge-only
    trig = s_reg.en && (fall || (!s_reg.sns && !req_pin_i));

    case (s_reg.src)
      CIS_SRC_TRAP:  win_vec = CIS_VEC_TRAP;
      CIS_SRC_EXT:   win_vec = CIS_VEC_EXT;
      CIS_SRC_TMR16: win_vec = CIS_VEC_TMR16;
      CIS_SRC_TMR8:  win_vec = CIS_VEC_TMR8;
      CIS_SRC_KEY:   win_vec = CIS_VEC_KEY;
      default:       win_vec = CIS_VEC_RESET;
    endcase

    // register reads
    if (rd) begin
      case (adr_i)
        CIS_MISC_OFS: begin
          s_next.dat = {24'h00_0000, s_reg.en, s_reg.sns, 3'h0, s_reg.ind, 2'h0};
        end

        CIS_CCR_OFS: begin
          s_next.dat = {24'h00_0000, s_reg.condition_code_reg};
        end

        CIS_STAT_OFS: begin
          // latch, state, source, busy from bit seven down
          s_next.dat = {24'h00_0000, s_reg.latch, s_reg.st, s_reg.src,
                        s_reg.busy || s_reg.trap_pend || s_reg.rti_pend};
        end

        CIS_PULL_OFS: begin
          s_next.dat = {16'h0000, s_reg.pulled[15:0]};
        end

        default: begin
          // unmapped reads answer zero
          s_next.dat = 32'h0000_0000;
        end
      endcase
    end

    // register writes
    if (wr) begin
      case (adr_i)
        CIS_MISC_OFS: begin
          // enable selects interrupt or indicator role
          s_next.en  = dat_i[CIS_MISC_EN_BIT];
          s_next.sns = dat_i[CIS_MISC_SNS_BIT];
          s_next.ind = dat_i[CIS_MISC_IND_BIT];
        end

        CIS_CMD_OFS: begin
          // trap is taken regardless of the mask
          if (dat_i[CIS_CMD_TRAP]) begin
            s_next.trap_pend = 1'b1;
          end
          if (dat_i[CIS_CMD_RTI]) begin
            s_next.rti_pend = 1'b1;
          end
          // of the commands, only clear-mask or wait clear the mask
          if (dat_i[CIS_CMD_CLI] || dat_i[CIS_CMD_WAIT]) begin
            s_next.condition_code_reg[CIS_CC_I] = 1'b0;
          end
          // set wins when both are asked at once
          if (dat_i[CIS_CMD_SEI]) begin
            s_next.condition_code_reg[CIS_CC_I] = 1'b1;
          end
        end

        CIS_ALU_OFS: begin
          if (cls != CIS_OP_BTST) begin
            s_next.condition_code_reg[CIS_CC_N] = res[7];
            s_next.condition_code_reg[CIS_CC_Z] = (res == 8'h00);
          end
          // carry kept on load, increment and decrement
          if (cls != CIS_OP_INCDC && cls != CIS_OP_LOAD) begin
            s_next.condition_code_reg[CIS_CC_C] = dat_i[CIS_ALU_C_BIT];
          end
          if (cls == CIS_OP_ADD) begin
            s_next.condition_code_reg[CIS_CC_H] = dat_i[CIS_ALU_H_BIT];
          end
        end

        default: begin
          // unmapped writes are acknowledged and dropped
        end
      endcase
    end

    // mask as this write leaves it: a clear-mask command that
    // also ends the instruction lets a waiting request in
    mask_now = s_next.condition_code_reg[CIS_CC_I];
    // masked or disabled external stays latched only
    pend_ext = s_reg.latch && s_reg.en && !mask_now;

    if (pend_ext) begin
      win = CIS_SRC_EXT;
    end else if (tmr16_req_i && !mask_now) begin
      win = CIS_SRC_TMR16;
    end else if (tmr8_req_i && !mask_now) begin
      win = CIS_SRC_TMR8;
    end else if (key_req_i && !mask_now) begin
      win = CIS_SRC_KEY;
    end

    // entry and return sequencing
    case (s_reg.st)
      ST_IDLE: begin
        // sources tested only at instruction end
        if (done_wr) begin
          if (s_next.rti_pend) begin
            s_next.st       = ST_PULL;
            s_next.cnt      = 3'h0;
            s_next.ccr_wait = 1'b1;
          // only a trap enters while the mask is set
          end else if (s_next.trap_pend || win != CIS_SRC_NONE) begin
            s_next.src       = s_next.trap_pend ? CIS_SRC_TRAP : win;
            s_next.trap_pend = 1'b0;
            // frame pcl, pch, x, a, ccr in push order
            s_next.frame = {pc_i[7:0], pc_i[15:8], idx_i, acc_i, s_next.condition_code_reg};
            s_next.st    = ST_PUSH;
            s_next.cnt   = 3'h0;
          end
        end
      end

      ST_PUSH: begin
        // five bytes pushed, sp wraps in its window
        s_next.stk_we  = 1'b1;
        s_next.stk_adr = CIS_SP_BASE | {10'h000, s_reg.sp};
        s_next.stk_dat = s_reg.frame[39:32];
        s_next.frame   = {s_reg.frame[31:0], 8'h00};
        s_next.sp      = s_reg.sp - 6'h01;
        s_next.cnt     = s_reg.cnt + 3'h1;
        if (s_reg.cnt == CIS_FRAME_LEN - 3'h1) begin
          s_next.st = ST_MASK;
        end
      end

      ST_MASK: begin
        // mask set after stacking, before vector
        s_next.condition_code_reg[CIS_CC_I] = 1'b1;
        s_next.st = ST_VEC;
      end

      ST_VEC: begin
        // reset vector comes from the boot pulse, not from here
        s_next.vf = 1'b1;
        s_next.va = win_vec;
        // latch cleared during external vector fetch
        if (s_reg.src == CIS_SRC_EXT) begin
          s_next.latch = 1'b0;
        end
        s_next.st = ST_IDLE;
      end

      ST_PULL: begin
        // pull ccr, a, x, pch, pcl in reverse
        // core answers each read strobe with a pull register write
        s_next.stk_re  = 1'b1;
        s_next.sp      = s_reg.sp + 6'h01;
        s_next.stk_adr = CIS_SP_BASE | {10'h000, s_next.sp};
        s_next.cnt     = s_reg.cnt + 3'h1;
        if (s_reg.cnt == CIS_FRAME_LEN - 3'h1) begin
          s_next.rti_pend = 1'b0;
          s_next.st = ST_IDLE;
        end
      end

      default: s_next.st = ST_IDLE;
    endcase

    // first pulled byte is the condition codes; it puts back
    // the old mask however late the core returns it
    if (pull_wr) begin
      s_next.pulled = {s_reg.pulled[31:0], dat_i[7:0]};
      if (s_reg.ccr_wait) begin
        s_next.condition_code_reg      = CIS_CC_UPPER | dat_i[7:0];
        s_next.ccr_wait = 1'b0;
      end
    end

    if (s_reg.boot) begin
      // reset vector first after any reset
      s_next.vf = 1'b1;
      s_next.va = CIS_VEC_RESET;
    end

    // set wins over the fetch clear, so no event is lost
    if (trig) begin
      s_next.latch = 1'b1;
    end

    // registered so these outputs leave a flop
    s_next.busy = (s_next.st != ST_IDLE);
    // pin driven low only as a lit indicator
    s_next.oe_n = s_next.en || !s_next.ind;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      // mask set, enable cleared by reset
      s_reg.condition_code_reg   <= CIS_CC_RESET;
      s_reg.sp    <= CIS_SP_RESET;
      s_reg.pin_d <= 1'b1;
      s_reg.boot  <= 1'b1;
      s_reg.oe_n  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dat_o          = s_reg.dat;
  assign ack_o          = s_reg.ack;
  assign stk_we_o       = s_reg.stk_we;
  assign stk_re_o       = s_reg.stk_re;
  assign stk_adr_o      = s_reg.stk_adr;
  assign stk_dat_o      = s_reg.stk_dat;
  assign vec_fetch_o    = s_reg.vf;
  assign vec_adr_o      = s_reg.va;
  assign ccr_o          = s_reg.condition_code_reg;
  assign busy_o         = s_reg.busy;
  // indicator drives low only when pin is not the request input
  assign req_pin_o      = 1'b0;
  assign req_pin_oe_n_o = s_reg.oe_n;
endmodule

// file: test/cis_pin_source.sv
// Purpose: external wired-or sources on the shared request pin
// Assumes: pin has a pull-up, device drives it low only as a lit indicator, with enable cleared
// Notes:   hold_low_i is raised by the bench once per pin mode
`timescale 1ns/1ps
module cis_pin_source (
  // bench control
  input  wire logic hold_low_i,
  // device side of the pin
  input  wire logic dev_o,
  input  wire logic dev_oe_n_i,
  // resolved pin level
  output logic      pin_o
);
  // hold low while hold_low_i is raised, served or not
  // released line floats back to the pull-up, never a stale value
  assign pin_o = !(hold_low_i || (!dev_oe_n_i && !dev_o));
endmodule

// file: test/cis_seq_assertions.sv
// Purpose: sequencing checks at the sequencer ports
// Assumes: core registers steady while a frame is pushed
// Notes:   single clock domain
`timescale 1ns/1ps
module cis_seq_assertions
  import cis_pkg::*;
(
  // clock, reset, bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  // core values
  input wire logic [15:0] pc_i,
  input wire logic [7:0]  acc_i,
  input wire logic [7:0]  idx_i,
  // sequence outputs
  input wire logic        stk_we_o,
  input wire logic        stk_re_o,
  input wire logic [7:0]  stk_dat_o,
  input wire logic        vec_fetch_o,
  input wire logic [15:0] vec_adr_o,
  input wire logic [7:0]  ccr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  reset_mask_a: assert property ($fell(rst_i) |-> ccr_o[CIS_CC_I])
    else $error("mask clear after reset");
  reset_vec_a: assert property ($fell(rst_i) |-> ##[0:2] (vec_fetch_o &&
    vec_adr_o == CIS_VEC_RESET)) else $error("no reset vector fetch");
  mask_order_a: assert property (vec_fetch_o && vec_adr_o != CIS_VEC_RESET
    |-> ccr_o[CIS_CC_I] && $past(stk_we_o, 2)) else $error("vector before mask");
  frame_len_a: assert property ($rose(stk_we_o) |-> stk_we_o[*5] ##1 !stk_we_o)
    else $error("push frame not five bytes");
  push_order_a: assert property ($rose(stk_we_o) |-> stk_dat_o == pc_i[7:0]
    ##1 stk_dat_o == pc_i[15:8] ##1 stk_dat_o == idx_i ##1 stk_dat_o == acc_i)
    else $error("push byte order wrong");
  masked_entry_a: assert property ($rose(stk_we_o) && ccr_o[CIS_CC_I]
    |-> ##6 (vec_fetch_o && vec_adr_o == CIS_VEC_TRAP)) else $error("masked entry");
  pull_len_a: assert property ($rose(stk_re_o) |-> stk_re_o[*5] ##1 !stk_re_o)
    else $error("pull frame not five bytes");
endmodule
bind cis_sequencer cis_seq_assertions cis_seq_assertions_inst (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pc_i(pc_i),
  .acc_i(acc_i), .idx_i(idx_i), .stk_we_o(stk_we_o), .stk_re_o(stk_re_o),
  .stk_dat_o(stk_dat_o), .vec_fetch_o(vec_fetch_o), .vec_adr_o(vec_adr_o),
  .ccr_o(ccr_o));

// file: test/cis_sequencer_test.sv
// Purpose: self-checking bench for the interrupt sequencer
// Assumes: one wishbone master, results noted in queues
// Notes:   unexpected vector fetches count as mismatches
`timescale 1ns/1ps
module cis_sequencer_test;
  import cis_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00, acc_i = 8'h00, idx_i = 8'h00, stk_dat_o, ccr_o;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, lfsr = 32'h3e12_703d;
  logic [15:0] pc_i = 16'h0000, vec_adr_o, stk_adr_o;
  logic        t16 = 1'b0, t8 = 1'b0, key = 1'b0, hold = 1'b0, pin, pin_o, pin_oe_n;
  logic        ack_o, stk_we_o, stk_re_o, vec_fetch_o, busy_o;
  logic [31:0] rd_q[$], msk_q[$];
  logic [15:0] vec_q[$];
  logic [31:0] alu[7] = '{32'h0000_1180, 32'h0000_0501, 32'h0000_0200, 32'h0000_147F,
                          32'h0000_0380, 32'h0000_2610, 32'h0000_1700};
  logic [7:0]  alu_cc[7] = '{8'hE5, 8'hE1, 8'hE2, 8'hE1, 8'hE5, 8'hF0, 8'hF1};
  int          errors = 0, tests_run = 0;
  always #4 clk_i = ~clk_i;
  cis_sequencer cis_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pc_i(pc_i), .acc_i(acc_i), .idx_i(idx_i),
    .tmr16_req_i(t16), .tmr8_req_i(t8), .key_req_i(key), .req_pin_i(pin),
    .req_pin_o(pin_o), .req_pin_oe_n_o(pin_oe_n), .stk_we_o(stk_we_o),
    .stk_re_o(stk_re_o), .stk_adr_o(stk_adr_o), .stk_dat_o(stk_dat_o),
    .vec_fetch_o(vec_fetch_o), .vec_adr_o(vec_adr_o), .busy_o(busy_o), .ccr_o(ccr_o));
  cis_pin_source cis_pin_source_inst (.hold_low_i(hold), .dev_o(pin_o),
    .dev_oe_n_i(pin_oe_n), .pin_o(pin));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 50) errors++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back(e & m);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0000_0000);
  endtask
  // random core values so every push carries fresh bytes
  task automatic cmd(input logic [31:0] c);
    int n;
    n = 0;
    lfsr = lfsr_next(lfsr);
    pc_i <= lfsr[15:0];
    acc_i <= lfsr[23:16];
    idx_i <= lfsr[31:24];
    wb(1'b1, CIS_CMD_OFS, c);
    repeat (2) @(posedge clk_i);
    while (busy_o === 1'b1 && n < 60) begin
      n++;
      @(posedge clk_i);
    end
    repeat (2) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0)
      chk(dat_o & msk_q.pop_front(), rd_q.pop_front());
    if (vec_fetch_o === 1'b1 && vec_q.size() == 0) chk({16'h0000, vec_adr_o}, 32'h0);
    else if (vec_fetch_o === 1'b1) chk({16'h0000, vec_adr_o}, {16'h0000, vec_q.pop_front()});
  end
  initial begin
    #200_000;
    errors++;
    conclude();
  end
  initial begin
    vec_q.push_back(CIS_VEC_RESET);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(CIS_CCR_OFS, 32'h0000_00E8, 32'h0000_00FF);
    rd(CIS_MISC_OFS, 32'h0000_0000, 32'h0000_0080);
    rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
    vec_q.push_back(CIS_VEC_TRAP);
    cmd(32'h0000_0003);
    cmd(32'h0000_0008);
    rd(CIS_CCR_OFS, 32'h0000_00E0, 32'h0000_00FF);
    $display("reset, trap and clear-mask test done");
    foreach (alu[i]) begin
      wb(1'b1, CIS_ALU_OFS, alu[i]);
      rd(CIS_CCR_OFS, {24'h0, alu_cc[i]}, 32'h0000_00FF);
    end
    $display("flag test done");
    cmd(32'h0000_0010);
    t16 <= 1'b1;
    key <= 1'b1;
    cmd(32'h0000_0001);
    vec_q.push_back(CIS_VEC_TMR16);
    cmd(32'h0000_0009);
    t16 <= 1'b0;
    t8 <= 1'b1;
    cmd(32'h0000_0001);
    vec_q.push_back(CIS_VEC_TMR8);
    vec_q.push_back(CIS_VEC_KEY);
    cmd(32'h0000_0009);
    t8 <= 1'b0;
    cmd(32'h0000_0009);
    key <= 1'b0;
    $display("priority test done");
    wb(1'b1, CIS_MISC_OFS, 32'h0000_0080);
    hold <= 1'b1;
    cmd(32'h0000_0001);
    vec_q.push_back(CIS_VEC_EXT);
    cmd(32'h0000_0009);
    vec_q.push_back(CIS_VEC_EXT);
    cmd(32'h0000_0009);
    hold <= 1'b0;
    wb(1'b1, CIS_MISC_OFS, 32'h0000_00C0);
    hold <= 1'b1;
    vec_q.push_back(CIS_VEC_EXT);
    cmd(32'h0000_0009);
    cmd(32'h0000_0009);
    hold <= 1'b0;
    wb(1'b1, CIS_MISC_OFS, 32'h0000_0000);
    hold <= 1'b1;
    cmd(32'h0000_0009);
    hold <= 1'b0;
    $display("external pin test done");
    cmd(32'h0000_0005);
    wb(1'b1, CIS_PULL_OFS, 32'h0000_000A);
    rd(CIS_CCR_OFS, 32'h0000_00EA, 32'h0000_00FF);
    rd(CIS_PULL_OFS, 32'h0000_000A, 32'h0000_00FF);
    $display("return test done");
    chk(vec_q.size(), 32'h0000_0000);
    conclude();
  end
endmodule
